// >>> testbench.sv
/*
 * Self-checking bench for tspc_ctrl, one task per scenario.
 * Assumes shortened tick and settle counts set below.
 */
`timescale 1ns/1ps
module testbench;
   import tspc_pkg::*;
   localparam int TICK = 10;
   localparam int STL = 8;
   logic sys_clk = 1'h0, sys_rst = 1'h1;
   logic load_check_enable = 1'h0, auto_scan_disable = 1'h0, thermistor_supply_force = 1'h0;
   logic die_overheat_action_disable = 1'h0, remote_overheat_action_disable = 1'h0;
   logic [SEL_W-1:0] analog_select_field = 4'h0;
   logic switch_wr = 1'h0, charge_switch_wdata = 1'h0, discharge_switch_wdata = 1'h0;
   logic balance_wr = 1'h0, overheat_flag_clear = 1'h0;
   logic [CELL_COUNT-1:0] balance_wdata = 7'h00;
   logic charge_overcurrent_flag = 1'h0, discharge_overcurrent_flag = 1'h0, short_circuit_flag = 1'h0;
   logic remote_hot = 1'h0, die_hot = 1'h0, load_attached = 1'h0;
   logic die_hot_in, thermistor_below_ref_in, load_divider_high_in;
   logic thermistor_supply_out, load_monitor_switch_on, load_present_flag, die_overheat_flag;
   logic remote_overheat_flag, charge_switch_ctrl, discharge_switch_ctrl, charge_switch_on;
   logic discharge_switch_on, remote_compare_active, protect_shutdown;
   logic [CELL_COUNT-1:0] balance_switch_on;
   logic [SEL_W-1:0] analog_route_sel;
   int errors = 0;
   int check_count = 0;

   tspc_ctrl #(.MS_TICK(TICK), .SETTLE(STL)) tspc_ctrl_i (.sys_clk, .sys_rst, .load_check_enable,
      .auto_scan_disable, .thermistor_supply_force, .die_overheat_action_disable,
      .remote_overheat_action_disable, .analog_select_field, .switch_wr, .charge_switch_wdata,
      .discharge_switch_wdata, .balance_wr, .balance_wdata, .overheat_flag_clear,
      .charge_overcurrent_flag, .discharge_overcurrent_flag, .short_circuit_flag, .die_hot_in,
      .thermistor_below_ref_in, .load_divider_high_in, .thermistor_supply_out, .load_monitor_switch_on,
      .load_present_flag, .die_overheat_flag, .remote_overheat_flag, .charge_switch_ctrl,
      .discharge_switch_ctrl, .charge_switch_on, .discharge_switch_on, .balance_switch_on,
      .analog_route_sel, .remote_compare_active, .protect_shutdown);
   tspc_analog_model tspc_analog_model_i (.sys_clk, .supply_on(thermistor_supply_out),
      .pull_down_on(load_monitor_switch_on), .remote_hot, .die_hot, .load_attached,
      .below_ref(thermistor_below_ref_in), .die_level(die_hot_in), .divider_high(load_divider_high_in));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   initial begin
      forever #20 sys_clk = ~sys_clk;
   end
   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wt(int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   // counts consecutive samples of the supply at lvl, capped at lim
   task automatic run(logic lvl, int lim, output int n);
      n = 0;
      while (thermistor_supply_out === lvl && n < lim) begin
         n++;
         wt(1);
      end
   endtask
   task automatic wr(bit bal, logic [6:0] d);
      @(posedge sys_clk);
      balance_wr <= bal;
      switch_wr <= ~bal;
      balance_wdata <= d;
      {charge_switch_wdata, discharge_switch_wdata} <= d[1:0];
      @(posedge sys_clk);
      {balance_wr, switch_wr} <= 2'h0;
      #1;
   endtask
   task automatic close_out();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_load();
      chk("balance at reset", 16'h0, 16'(balance_switch_on));
      chk("load switch at reset", 16'h0, 16'(load_monitor_switch_on));
      @(posedge sys_clk);
      load_check_enable <= 1'h1;
      load_attached <= 1'h1;
      wt(4);
      chk("load switch", 16'h1, 16'(load_monitor_switch_on));
      chk("load flag", 16'h1, 16'(load_present_flag));
      @(posedge sys_clk);
      load_attached <= 1'h0;
      wt(4);
      chk("load released", 16'h0, 16'(load_present_flag));
      @(posedge sys_clk);
      load_check_enable <= 1'h0;
      wt(4);
      chk("load switch off", 16'h0, 16'(load_monitor_switch_on));
   endtask
   task automatic t_scan();
      int n;
      run(1'h0, 7000, n);
      run(1'h1, 7000, n);
      run(1'h0, 7000, n);
      chk("scan off cycles", 16'((SCAN_PERIOD_MS - SCAN_ON_MS) * TICK), 16'(n));
      run(1'h1, 7000, n);
      chk("scan on cycles", 16'(SCAN_ON_MS * TICK), 16'(n));
      @(posedge sys_clk);
      auto_scan_disable <= 1'h1;
      run(1'h0, 7000, n);
      chk("scan stopped", 16'(7000), 16'(n));
   endtask
   task automatic t_select();
      int n;
      @(posedge sys_clk);
      analog_select_field <= SEL_EXT_TEMP;
      run(1'h0, 20, n);
      n = 0;
      while (remote_compare_active !== 1'h1 && n < 50) begin
         n++;
         wt(1);
      end
      chk("settle cycles", 16'(STL), 16'(n));
      chk("route", 16'(SEL_EXT_TEMP), 16'(analog_route_sel));
      run(1'h1, 300, n);
      chk("select holds supply", 16'(300), 16'(n));
      @(posedge sys_clk);
      analog_select_field <= SEL_RESET;
      thermistor_supply_force <= 1'h1;
      wt(3);
      run(1'h1, 300, n);
      chk("force holds supply", 16'(300), 16'(n));
      @(posedge sys_clk);
      thermistor_supply_force <= 1'h0;
      wt(3);
      chk("supply released", 16'h0, 16'(thermistor_supply_out));
   endtask
   task automatic t_heat(bit rem, bit dis);
      int n;
      logic f;
      wr(1'h0, 7'h03);
      wr(1'h1, 7'h55);
      @(posedge sys_clk);
      die_overheat_action_disable <= dis & ~rem;
      remote_overheat_action_disable <= dis & rem;
      analog_select_field <= rem ? SEL_EXT_TEMP : SEL_RESET;
      remote_hot <= rem;
      die_hot <= ~rem;
      n = 0;
      f = 1'h0;
      while (f !== 1'h1 && n < 40) begin
         n++;
         wt(1);
         f = rem ? remote_overheat_flag : die_overheat_flag;
      end
      chk("overheat flag", 16'h1, 16'(f));
      chk("shutdown", 16'(!dis), 16'(protect_shutdown));
      chk("ctrl bit", 16'(dis), 16'(charge_switch_ctrl));
      chk("ctrl bit dis", 16'(dis), 16'(discharge_switch_ctrl));
      chk("charge on", 16'(dis), 16'(charge_switch_on));
      chk("balance", dis ? 16'h55 : 16'h0, 16'(balance_switch_on));
      wr(1'h0, 7'h03);
      wr(1'h1, 7'h7f);
      chk("switch write", 16'(dis), 16'(discharge_switch_on));
      chk("switch write bit", 16'(dis), 16'(charge_switch_ctrl));
      chk("balance write", dis ? 16'h7f : 16'h0, 16'(balance_switch_on));
      @(posedge sys_clk);
      {remote_hot, die_hot} <= 2'h0;
      wt(8);
      chk("recovered", 16'h0, 16'(protect_shutdown));
      chk("flag held", 16'h1, 16'(rem ? remote_overheat_flag : die_overheat_flag));
      @(posedge sys_clk);
      overheat_flag_clear <= 1'h1;
      @(posedge sys_clk);
      overheat_flag_clear <= 1'h0;
      wt(1);
      chk("flag cleared", 16'h0, 16'(rem ? remote_overheat_flag : die_overheat_flag));
      chk("balance kept", dis ? 16'h7f : 16'h55, 16'(balance_switch_on));
   endtask
   task automatic t_wake();
      for (int i = 0; i < 3; i++) begin
         @(posedge sys_clk);
         {charge_overcurrent_flag, discharge_overcurrent_flag, short_circuit_flag} <= 3'h1 << i;
         wt(2);
         chk("wake supply", 16'h1, 16'(thermistor_supply_out));
         @(posedge sys_clk);
         {charge_overcurrent_flag, discharge_overcurrent_flag, short_circuit_flag} <= 3'h0;
         wt(2);
         chk("wake idle", 16'h0, 16'(thermistor_supply_out));
      end
   endtask

   initial begin
      #2000000;
      errors++;
      close_out();
   end
   initial begin
      wt(20);
      @(posedge sys_clk);
      sys_rst <= 1'h0;
      wt(1);
      t_load();
      t_scan();
      t_select();
      t_heat(1'b0, 1'b0);
      t_heat(1'b0, 1'b1);
      t_heat(1'b1, 1'b0);
      t_heat(1'b1, 1'b1);
      @(posedge sys_clk);
      analog_select_field <= SEL_RESET;
      wt(3);
      t_wake();
      close_out();
   end
endmodule

// >>> tspc_analog_model.sv
/*
 * Model of the analog section beside the control block: thermistor
 * comparator, die sensor and load divider.
 * Assumes condition levels from the bench and outputs of tspc_ctrl.
 */
`timescale 1ns/1ps
module tspc_analog_model (
   // clock
   input wire logic sys_clk,
   // from the block
   input wire logic supply_on,
   input wire logic pull_down_on,
   // conditions set by the bench
   input wire logic remote_hot,
   input wire logic die_hot,
   input wire logic load_attached,
   // comparator levels
   output logic below_ref,
   output logic die_level,
   output logic divider_high
);
   logic noise_reg = 1'h0;
   always_ff @(posedge sys_clk) begin
      noise_reg <= ~noise_reg;
   end
   // unpowered divider reads as noise, so only a settled reading may count
   assign below_ref = supply_on ? remote_hot : noise_reg;
   assign die_level = die_hot;
   // with the pull-down off the pin floats up near pack level
   assign divider_high = ~pull_down_on | load_attached;
endmodule

// >>> tspc_ctrl.sv
/*
 * Thermal scan and protection control: load monitor switch, periodic
 * thermistor supply scan with settle delay, over-temperature shutdown
 * of the power switches and cell balancing, analog selector.
 * Assumes control bits arrive from serial-port logic on sys_clk and
 * comparator levels arrive from the analog section unsynchronised.
 */
// Behaviour
// - load monitor off after reset; runs only while the enable bit is set
// - load check enable turns on the internal pull-down switch
// - load present flag clears once the divider shows the load released
// - default scan powers thermistor supply 5 ms in every 640 ms
// - wait 1 ms after supply on, then flag low thermistor voltage
// - selector on external temperature holds supply on, compares after settle
// - scan disable stops periodic scan; both scans otherwise coexist
// - supply force holds thermistor supply on over both scans
// - over-temperature opens switches, blocks balancing, sets matching flag
// - during shutdown switches stay off and writes to them are ignored
// - die action disable suppresses shutdown on internal over-temperature
// - remote action disable suppresses shutdown on external over-temperature
// - selector field routes the chosen analog source to the output
// - each balance bit drives one cell balancing switch
// - automatic switch-off also clears both switch control bits
// - any overcurrent or short flag drives thermistor supply high
`timescale 1ns/1ps
module tspc_ctrl #(
   parameter int MS_TICK = tspc_pkg::MS_TICK_CYC,
   parameter int SETTLE = tspc_pkg::SETTLE_CYC
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // control bits from the serial port
   input wire logic load_check_enable,
   input wire logic auto_scan_disable,
   input wire logic thermistor_supply_force,
   input wire logic die_overheat_action_disable,
   input wire logic remote_overheat_action_disable,
   input wire logic [tspc_pkg::SEL_W-1:0] analog_select_field,
   input wire logic switch_wr,
   input wire logic charge_switch_wdata,
   input wire logic discharge_switch_wdata,
   input wire logic balance_wr,
   input wire logic [tspc_pkg::CELL_COUNT-1:0] balance_wdata,
   input wire logic overheat_flag_clear,
   // overcurrent flags from the protection logic
   input wire logic charge_overcurrent_flag,
   input wire logic discharge_overcurrent_flag,
   input wire logic short_circuit_flag,
   // comparator levels from the analog section
   input wire logic die_hot_in,
   input wire logic thermistor_below_ref_in,
   input wire logic load_divider_high_in,
   // outputs
   output logic thermistor_supply_out,
   output logic load_monitor_switch_on,
   output logic load_present_flag,
   output logic die_overheat_flag,
   output logic remote_overheat_flag,
   output logic charge_switch_ctrl,
   output logic discharge_switch_ctrl,
   output logic charge_switch_on,
   output logic discharge_switch_on,
   output logic [tspc_pkg::CELL_COUNT-1:0] balance_switch_on,
   output logic [tspc_pkg::SEL_W-1:0] analog_route_sel,
   output logic remote_compare_active,
   output logic protect_shutdown
);
   import tspc_pkg::*;

   localparam logic [DIV_W-1:0] TICK_LAST = DIV_W'(MS_TICK - 1);
   localparam logic [DIV_W-1:0] SETTLE_LAST = DIV_W'(SETTLE - 1);

   tspc_state_t s_reg;
   tspc_state_t s_next;
   logic [2:0] cmp_sync;
   logic die_hot;
   logic therm_low;
   logic load_high;
   logic scan_on;
   logic sel_ext;
   logic supply_want;
   logic shut_now;

   tspc_sync2 u_sync (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .async_in({die_hot_in, thermistor_below_ref_in, load_divider_high_in}),
      .sync_out(cmp_sync)
   );

   assign die_hot = cmp_sync[2];
   assign therm_low = cmp_sync[1];
   assign load_high = cmp_sync[0];

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      s_next = s_reg;
      // millisecond enable pulse
      s_next.tick = 1'b0;
      if (s_reg.div == TICK_LAST) begin
         s_next.div = '0;
         s_next.tick = 1'b1;
      end else begin
         s_next.div = s_reg.div + 1'b1;
      end
      // period position keeps running even when disabled, so re-enabling is cheap
      if (s_reg.tick) begin
         s_next.scan_ms = (s_reg.scan_ms == SCAN_LAST) ? '0 : s_reg.scan_ms + 1'b1;
      end
      scan_on = !auto_scan_disable && (s_reg.scan_ms < SCAN_ON_END);
      sel_ext = (analog_select_field == SEL_EXT_TEMP);
      supply_want = scan_on || sel_ext || thermistor_supply_force
         || charge_overcurrent_flag || discharge_overcurrent_flag || short_circuit_flag;
      s_next.supply = supply_want;
      // settle counts from the first cycle the supply is high
      s_next.cmp_en = 1'b0;
      if (!s_reg.supply) begin
         s_next.settle = '0;
      end else if (s_reg.settle == SETTLE_LAST) begin
         s_next.cmp_en = 1'b1;
      end else begin
         s_next.settle = s_reg.settle + 1'b1;
      end
      // remote temperature state only updates from a settled reading
      if (s_reg.cmp_en) begin
         s_next.rem_hot = therm_low;
      end
      shut_now = (die_hot && !die_overheat_action_disable)
         || (s_reg.rem_hot && !remote_overheat_action_disable);
      s_next.shut = shut_now;
      // switch and balance bits; writes lost while shut down
      if (shut_now) begin
         s_next.chg = 1'b0;
         s_next.dis = 1'b0;
      end else begin
         if (switch_wr) begin
            s_next.chg = charge_switch_wdata;
            s_next.dis = discharge_switch_wdata;
         end
         if (balance_wr) begin
            s_next.bal = balance_wdata;
         end
      end
      s_next.chg_out = s_next.chg && !shut_now;
      s_next.dis_out = s_next.dis && !shut_now;
      s_next.bal_out = shut_now ? '0 : s_next.bal;
      // flags: clear only once recovered, and a new event beats the clear
      if (overheat_flag_clear && !die_hot) begin
         s_next.die_flag = 1'b0;
      end
      if (overheat_flag_clear && !s_reg.rem_hot) begin
         s_next.rem_flag = 1'b0;
      end
      if (die_hot) begin
         s_next.die_flag = 1'b1;
      end
      if (s_reg.rem_hot) begin
         s_next.rem_flag = 1'b1;
      end
      // load monitor
      s_next.ld_sw = load_check_enable;
      s_next.ld_flag = load_check_enable && load_high;
      s_next.asel = analog_select_field;
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         s_reg <= '0;
         s_reg.bal <= BAL_RESET;
         s_reg.bal_out <= BAL_RESET;
         s_reg.asel <= SEL_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   assign thermistor_supply_out = s_reg.supply;
   assign load_monitor_switch_on = s_reg.ld_sw;
   assign load_present_flag = s_reg.ld_flag;
   assign die_overheat_flag = s_reg.die_flag;
   assign remote_overheat_flag = s_reg.rem_flag;
   assign charge_switch_ctrl = s_reg.chg;
   assign discharge_switch_ctrl = s_reg.dis;
   assign charge_switch_on = s_reg.chg_out;
   assign discharge_switch_on = s_reg.dis_out;
   assign balance_switch_on = s_reg.bal_out;
   assign analog_route_sel = s_reg.asel;
   assign remote_compare_active = s_reg.cmp_en;
   assign protect_shutdown = s_reg.shut;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   chk_load_switch_follow: assert property (
      load_check_enable |=> load_monitor_switch_on)
      else $error("load switch not on after enable");
   chk_load_flag_gate: assert property (
      !load_monitor_switch_on |-> !load_present_flag)
      else $error("load flag without load monitor");
   // the reset term keeps the release edge out: supply is still cleared by reset there
   chk_scan_window: assert property (
      (!sys_rst && !auto_scan_disable && s_reg.scan_ms < SCAN_ON_END) |=> thermistor_supply_out)
      else $error("scan window without supply");
   chk_settle_wait: assert property (
      $rose(thermistor_supply_out) |-> !remote_compare_active [*8])
      else $error("compare before settle");
   chk_sel_supply: assert property (
      (analog_select_field == SEL_EXT_TEMP) |=> thermistor_supply_out)
      else $error("selector did not hold supply");
   chk_force_supply: assert property (
      thermistor_supply_force |=> thermistor_supply_out)
      else $error("force did not hold supply");
   chk_oc_wake: assert property (
      (charge_overcurrent_flag || discharge_overcurrent_flag || short_circuit_flag) |=> thermistor_supply_out)
      else $error("overcurrent did not raise supply");
   chk_shut_off: assert property (
      protect_shutdown |-> !charge_switch_on && !discharge_switch_on && balance_switch_on == '0)
      else $error("switches on in shutdown");
   chk_shut_clear: assert property (
      protect_shutdown |-> !charge_switch_ctrl && !discharge_switch_ctrl)
      else $error("control bits kept in shutdown");
   chk_die_disable: assert property (
      (die_overheat_action_disable && !s_reg.rem_hot) |=> !protect_shutdown)
      else $error("die shutdown despite disable");
   chk_rem_flag_hold: assert property (
      (remote_overheat_flag && s_reg.rem_hot) |=> remote_overheat_flag)
      else $error("remote flag dropped while hot");
   chk_bal_write: assert property (
      (balance_wr && !protect_shutdown && !shut_now) |=> balance_switch_on == $past(balance_wdata))
      else $error("balance write not applied");

   cov_scan_compare: cover property (remote_compare_active && !thermistor_supply_force);
   cov_remote_shut: cover property (s_reg.rem_hot && protect_shutdown);
   cov_load_release: cover property ($fell(load_present_flag) && load_monitor_switch_on);
   cov_flag_clear: cover property ($fell(die_overheat_flag));
endmodule

// >>> tspc_pkg.sv
/*
 * Shared constants of the thermal scan and protection control block:
 * timing figures, derived cycle counts, field widths and reset values.
 * Assumes a single 25 MHz system clock.
 */
package tspc_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 40;
   localparam int SCAN_ON_MS = 5;
   localparam int SCAN_PERIOD_MS = 640;
   localparam int SETTLE_MS = 1;
   localparam int MS_NS = 1000000;
   // one millisecond tick; a least time, so round up
   localparam int MS_TICK_CYC = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETTLE_CYC = (SETTLE_MS * MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // widths and codes
   // ----------------------------------------------------------------
   localparam int CELL_COUNT = 7;
   localparam int SEL_W = 4;
   localparam logic [SEL_W-1:0] SEL_EXT_TEMP = 4'h8;
   localparam logic [SEL_W-1:0] SEL_RESET = 4'h0;
   localparam logic [CELL_COUNT-1:0] BAL_RESET = 7'h00;
   localparam int DIV_W = 16;
   localparam int SCAN_W = 10;
   localparam logic [SCAN_W-1:0] SCAN_LAST = 10'(SCAN_PERIOD_MS - 1);
   localparam logic [SCAN_W-1:0] SCAN_ON_END = 10'(SCAN_ON_MS);

   typedef struct packed {
      logic [DIV_W-1:0] div;
      logic tick;
      logic [SCAN_W-1:0] scan_ms;
      logic [DIV_W-1:0] settle;
      logic cmp_en;
      logic supply;
      logic chg;
      logic dis;
      logic [CELL_COUNT-1:0] bal;
      logic ld_sw;
      logic ld_flag;
      logic die_flag;
      logic rem_flag;
      logic rem_hot;
      logic shut;
      logic chg_out;
      logic dis_out;
      logic [CELL_COUNT-1:0] bal_out;
      logic [SEL_W-1:0] asel;
   } tspc_state_t;

endpackage

// >>> tspc_sync2.sv
/*
 * Two-flop synchroniser for the analog comparator levels.
 * Assumes inputs are slow levels with no relation to sys_clk.
 */
`timescale 1ns/1ps
module tspc_sync2 (
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // levels
   input wire logic [2:0] async_in,
   output logic [2:0] sync_out
);
   typedef struct packed {
      logic [2:0] meta;
      logic [2:0] sync;
   } tspc_sync_state_t;

   tspc_sync_state_t s_reg;
   tspc_sync_state_t s_next;

   // only the second stage is read outside; the first may be metastable
   always_comb begin
      s_next.meta = async_in;
      s_next.sync = s_reg.meta;
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign sync_out = s_reg.sync;
endmodule
